//--- port_pin_defines.vh
// Register map, reset values and bus codes for the port pin block
`ifndef PORT_PIN_DEFINES_VH
`define PORT_PIN_DEFINES_VH

// ************************************************************
// Bus geometry
// ************************************************************
`define ADDR_W 8
`define DATA_W 32
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_PULLUP 8'h00
`define OFS_SLEW 8'h04
`define OFS_DRIVE 8'h08
`define OFS_FDIR 8'h0C
`define OFS_DATA 8'h10
`define OFS_DDIR 8'h14

// ************************************************************
// Field layout
// ************************************************************
`define FIRST_PINS 7
`define SECOND_PINS 8
`define FIRST_MASK 8'h7F

// ************************************************************
// Reset values
// ************************************************************
`define PULLUP_RST 7'h00
`define SLEW_RST 7'h7F
`define DRIVE_RST 7'h00
`define FDIR_RST 7'h00
`define DATA_RST 8'h00
`define DDIR_RST 8'h00

`endif

//--- pin_sync.v
// Two-flop synchroniser for the second port's pin levels
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] pin_async,
  output reg [7:0] pin_level_r
);

  reg [7:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= 8'h00;
      pin_level_r <= 8'h00;
    end
    else
    begin
      meta_r <= pin_async;
      pin_level_r <= meta_r;
    end
  end

endmodule

`default_nettype wire

//--- axil_slave.v
// AXI4-Lite handshake front end: one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_defines.vh"

module axil_slave (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  input wire [7:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  output wire wr_en,
  output reg [7:0] wr_addr_r,
  output reg [7:0] wr_data_r,
  output reg wr_lane0_r,
  input wire wr_err,
  input wire [7:0] rd_data,
  input wire rd_err
);

  reg aw_full_r;
  reg w_full_r;

  // Commit once both halves are in and the last answer is gone
  assign wr_en = aw_full_r & w_full_r & ~s_bvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      wr_lane0_r <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        wr_addr_r <= s_awaddr;
        aw_full_r <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        wr_data_r <= s_wdata[7:0];
        wr_lane0_r <= s_wstrb[0];
        w_full_r <= 1'b1;
        s_wready <= 1'b0;
      end
      if (wr_en)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // Read data captured at the address handshake
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= {24'h00_0000, rd_data};
      s_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

//--- port_pin_control.v
// Pin control of the seven-pin port and parallel I/O of the eight-pin port
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_defines.vh"

module port_pin_control (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_awaddr,
  input wire s_awvalid,
  output wire s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output wire s_wready,
  output wire [1:0] s_bresp,
  output wire s_bvalid,
  input wire s_bready,
  input wire [7:0] s_araddr,
  input wire s_arvalid,
  output wire s_arready,
  output wire [31:0] s_rdata,
  output wire [1:0] s_rresp,
  output wire s_rvalid,
  input wire s_rready,
  output reg [6:0] first_port_pin_oe_r,
  output reg [6:0] first_port_pullup_en_r,
  output reg [6:0] first_port_slew_limit_r,
  output reg [6:0] first_port_drive_high_r,
  input wire [7:0] second_port_pin_in,
  output reg [7:0] second_port_pin_out_r,
  output reg [7:0] second_port_pin_oe_r
);

  // ************************************************************
  // Software-visible state
  // ************************************************************
  reg [6:0] first_port_pullup_bits_r;
  reg [6:0] first_port_slew_bits_r;
  reg [6:0] first_port_drive_bits_r;
  reg [6:0] first_port_direction_bits_r;
  reg [7:0] second_port_data_latch_r;
  reg [7:0] second_port_direction_bits_r;

  reg [6:0] first_port_pullup_bits_nxt;
  reg [6:0] first_port_slew_bits_nxt;
  reg [6:0] first_port_drive_bits_nxt;
  reg [6:0] first_port_direction_bits_nxt;
  reg [7:0] second_port_data_latch_nxt;
  reg [7:0] second_port_direction_bits_nxt;

  // ************************************************************
  // Bus front end
  // ************************************************************
  wire wr_en;
  wire [7:0] wr_addr_r;
  wire [7:0] wr_data_r;
  wire wr_lane0_r;
  reg wr_err;
  reg [7:0] rd_data;
  reg rd_err;
  wire [7:0] second_port_level;

  axil_slave bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr_r(wr_addr_r),
    .wr_data_r(wr_data_r),
    .wr_lane0_r(wr_lane0_r),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // ************************************************************
  // Pin input synchronisation
  // ************************************************************
  // Pins are asynchronous to aclk, so reads see a two-cycle-old level
  pin_sync sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_async(second_port_pin_in),
    .pin_level_r(second_port_level)
  );

  // ************************************************************
  // Write address match
  // ************************************************************
  wire hit_pullup;
  wire hit_slew;
  wire hit_drive;
  wire hit_fdir;
  wire hit_data;
  wire hit_ddir;
  wire wr_commit;

  assign hit_pullup = (wr_addr_r == `OFS_PULLUP);
  assign hit_slew = (wr_addr_r == `OFS_SLEW);
  assign hit_drive = (wr_addr_r == `OFS_DRIVE);
  assign hit_fdir = (wr_addr_r == `OFS_FDIR);
  assign hit_data = (wr_addr_r == `OFS_DATA);
  assign hit_ddir = (wr_addr_r == `OFS_DDIR);
  // A write with lane 0 off is answered but commits nothing
  assign wr_commit = wr_en & wr_lane0_r;

  // ************************************************************
  // Write decode
  // ************************************************************
  always @*
  begin
    wr_err = 1'b0;
    case (wr_addr_r)
      `OFS_PULLUP,
      `OFS_SLEW,
      `OFS_DRIVE,
      `OFS_FDIR,
      `OFS_DATA,
      `OFS_DDIR:
        wr_err = 1'b0;
      default:
        wr_err = 1'b1;
    endcase
  end

  // Only byte lane 0 holds register bits; upper lanes are dropped
  always @*
  begin
    first_port_pullup_bits_nxt = first_port_pullup_bits_r;
    first_port_slew_bits_nxt = first_port_slew_bits_r;
    first_port_drive_bits_nxt = first_port_drive_bits_r;
    first_port_direction_bits_nxt = first_port_direction_bits_r;
    second_port_data_latch_nxt = second_port_data_latch_r;
    second_port_direction_bits_nxt = second_port_direction_bits_r;
    if (wr_commit && hit_pullup)
    begin
      first_port_pullup_bits_nxt = wr_data_r[6:0];
    end
    if (wr_commit && hit_slew)
    begin
      first_port_slew_bits_nxt = wr_data_r[6:0];
    end
    if (wr_commit && hit_drive)
    begin
      first_port_drive_bits_nxt = wr_data_r[6:0];
    end
    if (wr_commit && hit_fdir)
    begin
      first_port_direction_bits_nxt = wr_data_r[6:0];
    end
    // Input pins' bits are latched too, ready for a turn-around
    if (wr_commit && hit_data)
    begin
      second_port_data_latch_nxt = wr_data_r;
    end
    if (wr_commit && hit_ddir)
    begin
      second_port_direction_bits_nxt = wr_data_r;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      first_port_pullup_bits_r <= `PULLUP_RST;
      first_port_slew_bits_r <= `SLEW_RST;
      first_port_drive_bits_r <= `DRIVE_RST;
      first_port_direction_bits_r <= `FDIR_RST;
      second_port_data_latch_r <= `DATA_RST;
      second_port_direction_bits_r <= `DDIR_RST;
    end
    else
    begin
      first_port_pullup_bits_r <= first_port_pullup_bits_nxt;
      first_port_slew_bits_r <= first_port_slew_bits_nxt;
      first_port_drive_bits_r <= first_port_drive_bits_nxt;
      first_port_direction_bits_r <= first_port_direction_bits_nxt;
      second_port_data_latch_r <= second_port_data_latch_nxt;
      second_port_direction_bits_r <= second_port_direction_bits_nxt;
    end
  end

  // ************************************************************
  // Read decode
  // ************************************************************
  wire [7:0] second_port_read;

  // Per-bit source: latch when driven, pin level when an input
  genvar d;
  generate
    for (d = 0; d < `SECOND_PINS; d = d + 1)
    begin : rd_sel
      assign second_port_read[d] = second_port_direction_bits_r[d] ?
        second_port_data_latch_r[d] :
        second_port_level[d];
    end
  endgenerate

  // ************************************************************
  // Read address match
  // ************************************************************
  wire rd_hit_pullup;
  wire rd_hit_slew;
  wire rd_hit_drive;
  wire rd_hit_fdir;
  wire rd_hit_data;
  wire rd_hit_ddir;
  wire rd_hit_any;

  assign rd_hit_pullup = (s_araddr == `OFS_PULLUP);
  assign rd_hit_slew = (s_araddr == `OFS_SLEW);
  assign rd_hit_drive = (s_araddr == `OFS_DRIVE);
  assign rd_hit_fdir = (s_araddr == `OFS_FDIR);
  assign rd_hit_data = (s_araddr == `OFS_DATA);
  assign rd_hit_ddir = (s_araddr == `OFS_DDIR);
  // Anything else is a hole in the map and answers with an error
  assign rd_hit_any = rd_hit_pullup | rd_hit_slew | rd_hit_drive |
    rd_hit_fdir | rd_hit_data | rd_hit_ddir;

  always @*
  begin
    rd_data = 8'h00;
    rd_err = ~rd_hit_any;
    case (s_araddr)
      `OFS_PULLUP:
        rd_data = {1'b0, first_port_pullup_bits_r};
      `OFS_SLEW:
        rd_data = {1'b0, first_port_slew_bits_r};
      `OFS_DRIVE:
        rd_data = {1'b0, first_port_drive_bits_r};
      `OFS_FDIR:
        rd_data = {1'b0, first_port_direction_bits_r};
      `OFS_DATA:
        rd_data = second_port_read;
      `OFS_DDIR:
        rd_data = second_port_direction_bits_r;
      default:
        rd_data = 8'h00;
    endcase
  end

  // ************************************************************
  // First port pin control
  // ************************************************************
  reg [6:0] first_port_pin_oe_nxt;
  reg [6:0] first_port_pullup_en_nxt;
  reg [6:0] first_port_slew_limit_nxt;
  reg [6:0] first_port_drive_high_nxt;

  genvar c;
  generate
    for (c = 0; c < `FIRST_PINS; c = c + 1)
    begin : first_ctl
      always @*
      begin
        // Direction decides which pad control applies
        first_port_pin_oe_nxt[c] = first_port_direction_bits_r[c];
        // An output never fights its own pullup
        first_port_pullup_en_nxt[c] = first_port_pullup_bits_r[c] &
          ~first_port_direction_bits_r[c];
        // Slew limiting is meaningless on an undriven pad
        first_port_slew_limit_nxt[c] = first_port_slew_bits_r[c] &
          first_port_direction_bits_r[c];
        first_port_drive_high_nxt[c] = first_port_drive_bits_r[c];
      end
    end
  endgenerate

  // Registered so pad controls never glitch on decode changes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      first_port_pin_oe_r <= 7'h00;
      first_port_pullup_en_r <= 7'h00;
      first_port_slew_limit_r <= 7'h00;
      first_port_drive_high_r <= 7'h00;
    end
    else
    begin
      first_port_pin_oe_r <= first_port_pin_oe_nxt;
      first_port_pullup_en_r <= first_port_pullup_en_nxt;
      first_port_slew_limit_r <= first_port_slew_limit_nxt;
      first_port_drive_high_r <= first_port_drive_high_nxt;
    end
  end

  // ************************************************************
  // Second port pin drive
  // ************************************************************
  genvar p;
  generate
    for (p = 0; p < `SECOND_PINS; p = p + 1)
    begin : second_drv
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          second_port_pin_out_r[p] <= 1'b0;
          second_port_pin_oe_r[p] <= 1'b0;
        end
        else
        begin
          second_port_pin_out_r[p] <= second_port_data_latch_r[p];
          second_port_pin_oe_r[p] <=
            second_port_direction_bits_r[p];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- port_pin_control_asserts.sv
// Concurrent checks on the ports of the port pin block
`timescale 1ns/1ps
`default_nettype none
module port_pin_control_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [6:0] first_port_pin_oe_r,
  input wire logic [6:0] first_port_pullup_en_r,
  input wire logic [6:0] first_port_slew_limit_r,
  input wire logic [6:0] first_port_drive_high_r,
  input wire logic [7:0] second_port_pin_in,
  input wire logic [7:0] second_port_pin_out_r,
  input wire logic [7:0] second_port_pin_oe_r
);
  default clocking cb @(posedge aclk);
  endclocking
  // Held off one edge past release so pre-reset levels never count
  logic run_r = 1'b0;
  always @(posedge aclk)
    run_r <= aresetn;
  default disable iff (!aresetn || !run_r);
  // ****************************************
  // Bus handshakes
  // ****************************************
  sequence wr_take;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence rd_take;
    s_arvalid && s_arready;
  endsequence
  a_write_answer: assert property (wr_take |=>
    !s_bvalid ##1 s_bvalid) else $error("write answer late");
  a_read_answer: assert property (rd_take |=> s_rvalid)
    else $error("read answer late");
  a_resp_hold: assert property (s_bvalid && !s_bready |=>
    s_bvalid && $stable(s_bresp)) else $error("write answer dropped");
  a_read_hold: assert property (s_rvalid && !s_rready |=>
    s_rvalid && $stable(s_rdata)) else $error("read data dropped");
  // ****************************************
  // Pin outputs
  // ****************************************
  a_pullup_off: assert property ((first_port_pullup_en_r &
    first_port_pin_oe_r) == 7'h00) else $error("pullup on output pin");
  a_slew_inputs: assert property ((first_port_slew_limit_r &
    ~first_port_pin_oe_r) == 7'h00) else $error("slew on input pin");
  a_reset_idle: assert property ($rose(aresetn) |->
    {first_port_pin_oe_r, first_port_pullup_en_r, second_port_pin_oe_r,
    second_port_pin_out_r} == 30'h0000_0000) else $error("pins not idle");
  a_pins_on_write: assert property ($changed({first_port_pin_oe_r,
    first_port_pullup_en_r, first_port_slew_limit_r, first_port_drive_high_r,
    second_port_pin_out_r, second_port_pin_oe_r}) |->
    $past(s_bvalid) && !$past(s_bvalid, 2))
    else $error("pins moved without write");
endmodule
bind port_pin_control port_pin_control_asserts i_port_pin_control_asserts (.*);
`default_nettype wire

//--- pin_board.sv
// Board-side model of what hangs on the eight-pin port
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input wire logic aclk,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] ext_level,
  input wire logic [7:0] ext_drive,
  output logic [7:0] pin_level
);
  logic [7:0] float_r = 8'h55;
  // Undriven lines wander so a stale level never passes as a read
  always @(posedge aclk)
    float_r <= ~float_r;
  // Device driver wins; the board drives only released pins
  always_comb
    pin_level = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level) |
      (~pin_oe & ~ext_drive & float_r);
endmodule
`default_nettype wire

//--- port_pin_control_test.sv
// Self-checking bench for the port pin block
`timescale 1ns/1ps
`default_nettype none
module port_pin_control_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic [31:0] s_wdata = 32'h0000_0000;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic [7:0] s_araddr = 8'h00;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [6:0] first_port_pin_oe_r, first_port_pullup_en_r;
  logic [6:0] first_port_slew_limit_r, first_port_drive_high_r;
  logic [7:0] second_port_pin_out_r, second_port_pin_oe_r, pin_lvl;
  logic [7:0] ext = 8'h00;
  logic [7:0] ext_drive = 8'hff;
  logic [7:0] m [0:5];
  logic [31:0] seed = 32'h0001_44f8;
  int fails = 0;
  int comparisons = 0;
  port_pin_control i_port_pin_control (.second_port_pin_in(pin_lvl), .*);
  pin_board i_pin_board (.aclk(aclk), .pin_oe(second_port_pin_oe_r),
    .pin_out(second_port_pin_out_r), .ext_level(ext),
    .ext_drive(ext_drive), .pin_level(pin_lvl));
  initial
  begin
    forever #50 aclk = ~aclk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic do_reset(input int cyc);
    aresetn <= 1'b0;
    repeat (cyc) @(posedge aclk);
    aresetn <= 1'b1;
    m = '{8'h00, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00};
  endtask
  // Ready is raised a cycle late at random, still ahead of the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] st, output logic [1:0] rs);
    logic [31:0] r;
    int n;
    r = rnd();
    n = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= r[0];
    do
    begin
      @(posedge aclk);
      n++;
      if (s_awready)
        s_awvalid <= 1'b0;
      if (s_wready)
        s_wvalid <= 1'b0;
      if (!s_bready)
        s_bready <= 1'b1;
    end
    while (!(s_bvalid && s_bready) && n < 60);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic rd_chk(input int k);
    logic [31:0] r;
    logic [7:0] e;
    int n;
    r = rnd();
    n = 0;
    e = k == 4 ? (m[4] & m[5]) | (ext & ~m[5]) : k < 6 ? m[k] : 8'h00;
    @(posedge aclk);
    s_araddr <= 8'(k * 4);
    s_arvalid <= 1'b1;
    s_rready <= r[0];
    do
    begin
      @(posedge aclk);
      n++;
      if (s_arready)
        s_arvalid <= 1'b0;
      if (!s_rready)
        s_rready <= 1'b1;
    end
    while (!(s_rvalid && s_rready) && n < 60);
    chk("rdata", s_rdata, {24'h00_0000, e});
    chk("rresp", s_rresp, k < 6 ? 2'h0 : 2'h2);
    s_rready <= 1'b0;
  endtask
  task automatic pins();
    @(negedge aclk);
    chk("first_oe", first_port_pin_oe_r, m[3]);
    chk("pullup", first_port_pullup_en_r, m[0] & ~m[3]);
    chk("slew", first_port_slew_limit_r, m[1] & m[3]);
    chk("drive", first_port_drive_high_r, m[2]);
    chk("pin_out", second_port_pin_out_r, m[4]);
    chk("pin_oe", second_port_pin_oe_r, m[5]);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [31:0] r, d;
    logic [1:0] rs;
    int k;
    do_reset(6);
    pins();
    for (int i = 0; i < 8; i++)
      rd_chk(i);
    for (int i = 0; i < 60; i++)
    begin
      if (i == 40)
      begin
        @(posedge aclk);
        do_reset(2);
        pins();
      end
      r = rnd();
      d = rnd();
      k = r[2:0] % 7;
      wr(8'(k * 4), d, (r[5:3] == 0 && k < 6) ? 4'he : 4'hf, rs);
      chk("bresp", rs, k < 6 ? 2'h0 : 2'h2);
      if (k < 6 && r[5:3] != 0)
        m[k] = k < 4 ? d[7:0] & 8'h7f : d[7:0];
      pins();
      @(posedge aclk);
      ext <= r[15:8];
      repeat (3) @(posedge aclk);
      rd_chk(r[18:16]);
    end
    final_report();
  end
  initial
  begin
    repeat (6000) @(posedge aclk);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
